// file: irq_route_pkg.sv
// Constants and helpers shared by the mailbox interrupt routing block
// Functional notes
// - Core C owns mailboxes 4C to 4C+3
// - Fast route bit set: nonzero mailbox raises fast
// - Normal route bit set: nonzero mailbox raises normal
// - Fast route overrides normal route, never both
// - Per-core read-only cause of normal request
// - Cause bit 30: level-two cache bus error
// - Cause bit 10: bus quiet, core 0 only
// - Cause bits 7:4: core's four mailbox interrupts
// - Bits 11 timer, 9 perf, 8 graphics
// - Bits 3:0: generic timer tick events
// - Route control registers reset to zero
package irq_route_pkg;

	localparam int NUM_CORES      = 4;
	localparam int BOXES_PER_CORE = 4;
	localparam int NUM_BOXES      = NUM_CORES * BOXES_PER_CORE;
	localparam int BOX_W          = 32;
	localparam int DATA_W         = 32;
	localparam int ADDR_W         = 8;
	localparam int CTRL_W         = 8;
	localparam int EVT_W          = 2 * NUM_CORES;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [ADDR_W-1:0] CTRL_BASE  = 8'h00;
	localparam logic [ADDR_W-1:0] CAUSE_BASE = 8'h10;
	localparam logic [ADDR_W-1:0] EVT_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] EVT_MASK   = 8'h24;
	localparam logic [ADDR_W-1:0] BANK_MASK  = 8'hf0;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_NORM_LSB   = 0;
	localparam int CTRL_FAST_LSB   = 4;
	localparam int CAUSE_TICK_LSB  = 0;
	localparam int CAUSE_BOX_LSB   = 4;
	localparam int CAUSE_GPU_BIT   = 8;
	localparam int CAUSE_PERF_BIT  = 9;
	localparam int CAUSE_QUIET_BIT = 10;
	localparam int CAUSE_TIMER_BIT = 11;
	localparam int CAUSE_L2ERR_BIT = 30;
	localparam int QUIET_CORE      = 0;
	localparam int EVT_FAST_LSB    = 0;
	localparam int EVT_NORM_LSB    = NUM_CORES;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [EVT_W-1:0]  EVT_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;

	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_SETUP  = 2'b01,
		PH_ACCESS = 2'b11
	} apb_phase_t;

	// Word index inside a four-register bank
	function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] addr);
		return addr[3:2];
	endfunction

	function automatic logic word_nonzero(input logic [BOX_W-1:0] word);
		return |word;
	endfunction

endpackage

// file: core_route.sv
// Routing of one core's four mailboxes onto fast and normal requests
`timescale 1ns/1ps
module core_route (
	// Route control of this core
	input  wire logic [irq_route_pkg::CTRL_W-1:0]                          ctrl,
	// The core's own four mailboxes, first at the bottom
	input  wire logic [irq_route_pkg::BOXES_PER_CORE*irq_route_pkg::BOX_W-1:0] box_words,
	// Per-mailbox contributions
	output logic      [irq_route_pkg::BOXES_PER_CORE-1:0]                  fast_bits,
	output logic      [irq_route_pkg::BOXES_PER_CORE-1:0]                  norm_bits
);

	logic [irq_route_pkg::BOXES_PER_CORE-1:0] busy;
	logic [irq_route_pkg::BOXES_PER_CORE-1:0] fast_en;
	logic [irq_route_pkg::BOXES_PER_CORE-1:0] norm_en;

	assign fast_en = ctrl[irq_route_pkg::CTRL_FAST_LSB +: irq_route_pkg::BOXES_PER_CORE];
	assign norm_en = ctrl[irq_route_pkg::CTRL_NORM_LSB +: irq_route_pkg::BOXES_PER_CORE];

	always_comb begin
		for (int k = 0; k < irq_route_pkg::BOXES_PER_CORE; k++) begin
			busy[k] = irq_route_pkg::word_nonzero(
				box_words[k*irq_route_pkg::BOX_W +: irq_route_pkg::BOX_W]);
		end
	end

	assign fast_bits = busy & fast_en;
	// Fast route masks the normal one so an event never reaches both pins
	assign norm_bits = busy & norm_en & ~fast_en;

endmodule

// file: event_sticky.sv
// Sticky event status with read-clear, mask and one level interrupt
`timescale 1ns/1ps
module event_sticky (
	// Clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	// Events and software access
	input  wire logic [irq_route_pkg::EVT_W-1:0] evt_pulse,
	input  wire logic                            status_rd,
	input  wire logic                            mask_wr,
	input  wire logic [irq_route_pkg::EVT_W-1:0] mask_wdata,
	// State
	output logic      [irq_route_pkg::EVT_W-1:0] status_ff,
	output logic      [irq_route_pkg::EVT_W-1:0] mask_ff,
	output logic                                 event_irq
);

	logic [irq_route_pkg::EVT_W-1:0] nxt_status;

	// A new event in the clearing read cycle survives the clear
	always_comb begin
		nxt_status = status_rd ? evt_pulse : (status_ff | evt_pulse);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_ff <= irq_route_pkg::EVT_RESET;
		end else begin
			status_ff <= nxt_status;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mask_ff <= irq_route_pkg::EVT_RESET;
		end else if (mask_wr) begin
			mask_ff <= mask_wdata;
		end
	end

	assign event_irq = |(status_ff & mask_ff);

endmodule

// file: mailbox_irq_router.sv
// Mailbox interrupt routing, per-core cause registers and APB slave
`timescale 1ns/1ps
module mailbox_irq_router (
	// Clock and reset
	input  wire logic                                            sys_clk,
	input  wire logic                                            rst,
	// APB slave
	input  wire logic [irq_route_pkg::ADDR_W-1:0]                paddr,
	input  wire logic                                            psel,
	input  wire logic                                            penable,
	input  wire logic                                            pwrite,
	input  wire logic [irq_route_pkg::DATA_W-1:0]                pwdata,
	input  wire logic [3:0]                                      pstrb,
	output logic      [irq_route_pkg::DATA_W-1:0]                prdata,
	output logic                                                 pready,
	output logic                                                 pslverr,
	// Contents of all sixteen mailboxes, mailbox 0 at the bottom
	input  wire logic [irq_route_pkg::NUM_BOXES*irq_route_pkg::BOX_W-1:0] box_words,
	// Other normal sources, one bit per core except tick_normal, four per core, and bus_quiet, one bit
	input  wire logic [irq_route_pkg::NUM_CORES*4-1:0]           tick_normal,
	input  wire logic [irq_route_pkg::NUM_CORES-1:0]             local_timer_int,
	input  wire logic [irq_route_pkg::NUM_CORES-1:0]             perf_monitor_int,
	input  wire logic [irq_route_pkg::NUM_CORES-1:0]             gpu_int,
	input  wire logic [irq_route_pkg::NUM_CORES-1:0]             l2_bus_error,
	input  wire logic                                            bus_quiet,
	// Requests to the cores
	output logic      [irq_route_pkg::NUM_CORES-1:0]             fast_req,
	output logic      [irq_route_pkg::NUM_CORES-1:0]             normal_req,
	// Event interrupt
	output logic                                                 event_irq
);

	localparam int NC = irq_route_pkg::NUM_CORES;
	localparam int NB = irq_route_pkg::BOXES_PER_CORE;
	localparam int BW = irq_route_pkg::BOX_W;
	localparam int DW = irq_route_pkg::DATA_W;
	localparam int CW = irq_route_pkg::CTRL_W;
	localparam int EW = irq_route_pkg::EVT_W;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	irq_route_pkg::apb_phase_t phase_ff;
	irq_route_pkg::apb_phase_t nxt_phase;

	logic [CW-1:0] ctrl_ff [NC];
	logic [NB-1:0] fast_bits [NC];
	logic [NB-1:0] norm_bits [NC];
	logic [DW-1:0] cause [NC];

	logic [NC-1:0] nxt_fast;
	logic [NC-1:0] nxt_normal;
	logic [NC-1:0] fast_ff;
	logic [NC-1:0] normal_ff;

	logic [EW-1:0] evt_pulse;
	logic [EW-1:0] evt_status;
	logic [EW-1:0] evt_mask;

	logic [DW-1:0] prdata_ff;
	logic [DW-1:0] nxt_rdata;

	logic          setup_cyc;
	logic          access_cyc;
	logic          wr_done;
	logic          rd_done;
	logic          hit_ctrl;
	logic          hit_cause;
	logic          hit_status;
	logic          hit_mask;
	logic          addr_ok;
	logic          first_acc;
	logic [1:0]    idx;

	////////////////////////////////////////////////////////////////////////
	// APB phase tracking

	always_comb begin
		nxt_phase = irq_route_pkg::PH_IDLE;
		unique case (phase_ff)
			irq_route_pkg::PH_IDLE: begin
				if (psel) begin
					nxt_phase = irq_route_pkg::PH_SETUP;
				end
			end
			irq_route_pkg::PH_SETUP: begin
				nxt_phase = irq_route_pkg::PH_ACCESS;
			end
			irq_route_pkg::PH_ACCESS: begin
				// Back-to-back transfer enters setup directly
				if (psel && !penable) begin
					nxt_phase = irq_route_pkg::PH_SETUP;
				end
			end
			default: begin
				nxt_phase = irq_route_pkg::PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phase_ff <= irq_route_pkg::PH_IDLE;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// Setup cycle is judged from the pins so read data is ready for access
	assign setup_cyc  = psel && !penable;
	assign access_cyc = psel && penable;

	////////////////////////////////////////////////////////////////////////
	// Address decode

	assign idx        = irq_route_pkg::reg_index(paddr);
	assign hit_ctrl   = (paddr & irq_route_pkg::BANK_MASK) == irq_route_pkg::CTRL_BASE;
	assign hit_cause  = (paddr & irq_route_pkg::BANK_MASK) == irq_route_pkg::CAUSE_BASE;
	assign hit_status = paddr == irq_route_pkg::EVT_STATUS;
	assign hit_mask   = paddr == irq_route_pkg::EVT_MASK;

	// Unaligned addresses and writes to read-only words answer with an error
	always_comb begin
		addr_ok = 1'b0;
		if (paddr[1:0] == 2'b00) begin
			if (hit_ctrl || hit_mask) begin
				addr_ok = 1'b1;
			end else if (hit_cause || hit_status) begin
				addr_ok = !pwrite;
			end
		end
	end

	// Zero wait states: read data was captured in the setup cycle
	assign pready  = access_cyc;
	assign pslverr = access_cyc && !addr_ok;
	assign prdata  = prdata_ff;

	// Only an access with the phase in setup is taken: a stuck penable
	// repeats a write or a status clear once every three cycles
	assign first_acc = phase_ff == irq_route_pkg::PH_SETUP;
	assign wr_done   = access_cyc && first_acc && pwrite && addr_ok;
	assign rd_done   = access_cyc && first_acc && !pwrite && addr_ok;

	////////////////////////////////////////////////////////////////////////
	// Route control registers

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int c = 0; c < NC; c++) begin
				ctrl_ff[c] <= irq_route_pkg::CTRL_RESET;
			end
		end else if (wr_done && hit_ctrl && pstrb[0]) begin
			// Only the low byte is stored; upper lanes are dropped
			ctrl_ff[idx] <= pwdata[CW-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-core routing

	for (genvar c = 0; c < NC; c++) begin : g_core
		core_route u_route (
			.ctrl      (ctrl_ff[c]),
			.box_words (box_words[c*NB*BW +: NB*BW]),
			.fast_bits (fast_bits[c]),
			.norm_bits (norm_bits[c])
		);

		always_comb begin
			cause[c] = irq_route_pkg::WORD_ZERO;
			cause[c][irq_route_pkg::CAUSE_TICK_LSB +: 4] =
				tick_normal[c*4 +: 4];
			cause[c][irq_route_pkg::CAUSE_BOX_LSB +: NB] = norm_bits[c];
			cause[c][irq_route_pkg::CAUSE_GPU_BIT]   = gpu_int[c];
			cause[c][irq_route_pkg::CAUSE_PERF_BIT]  = perf_monitor_int[c];
			cause[c][irq_route_pkg::CAUSE_TIMER_BIT] = local_timer_int[c];
			cause[c][irq_route_pkg::CAUSE_L2ERR_BIT] = l2_bus_error[c];
			if (c == irq_route_pkg::QUIET_CORE) begin
				cause[c][irq_route_pkg::CAUSE_QUIET_BIT] = bus_quiet;
			end
		end

		assign nxt_fast[c]   = |fast_bits[c];
		assign nxt_normal[c] = |cause[c];
	end

	////////////////////////////////////////////////////////////////////////
	// Request pins, registered so the cores see clean levels

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fast_ff <= '0;
		end else begin
			fast_ff <= nxt_fast;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			normal_ff <= '0;
		end else begin
			normal_ff <= nxt_normal;
		end
	end

	assign fast_req   = fast_ff;
	assign normal_req = normal_ff;

	////////////////////////////////////////////////////////////////////////
	// Events: a request pin going high

	assign evt_pulse[irq_route_pkg::EVT_FAST_LSB +: NC] = nxt_fast & ~fast_ff;
	assign evt_pulse[irq_route_pkg::EVT_NORM_LSB +: NC] = nxt_normal & ~normal_ff;

	event_sticky u_events (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.evt_pulse  (evt_pulse),
		.status_rd  (rd_done && hit_status),
		.mask_wr    (wr_done && hit_mask && pstrb[0]),
		.mask_wdata (pwdata[EW-1:0]),
		.status_ff  (evt_status),
		.mask_ff    (evt_mask),
		.event_irq  (event_irq)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data

	always_comb begin
		nxt_rdata = irq_route_pkg::WORD_ZERO;
		if (paddr[1:0] == 2'b00 && !pwrite) begin
			if (hit_ctrl) begin
				nxt_rdata[CW-1:0] = ctrl_ff[idx];
			end else if (hit_cause) begin
				nxt_rdata = cause[idx];
			end else if (hit_status) begin
				nxt_rdata[EW-1:0] = evt_status;
			end else if (hit_mask) begin
				nxt_rdata[EW-1:0] = evt_mask;
			end
		end
	end

	// Sampled in setup; cause seen is the value one cycle before the access
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata_ff <= irq_route_pkg::WORD_ZERO;
		end else if (setup_cyc) begin
			prdata_ff <= nxt_rdata;
		end
	end

endmodule

// file: route_checker.sv
// Port-level checks of the mailbox interrupt router
`timescale 1ns/1ps
module route_checker (
	// Clock and reset
	input wire logic         sys_clk,
	input wire logic         rst,
	// APB
	input wire logic [7:0]   paddr,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic         pslverr,
	// Mailboxes and requests
	input wire logic [511:0] box_words,
	input wire logic [3:0]   fast_req,
	input wire logic [3:0]   normal_req
);
	logic [3:0] box_any;
	logic       acc;
	assign acc = psel && penable;
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			box_any[c] = |box_words[c*128 +: 128];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	AST_RST_FAST: assert property (disable iff (1'b0) rst |=> fast_req == 4'h0)
		else $error("fast request not cleared by reset");
	AST_NORM_RST: assert property (disable iff (1'b0) rst |=> normal_req == 4'h0)
		else $error("normal request not cleared by reset");
	// Earliest write lands one edge after rst is first sampled low, fast_req rises on the next
	AST_ROUTE_OFF: assert property ($fell(rst) |-> (fast_req == 4'h0) [*3])
		else $error("fast request before any route enabled");
	AST_FAST_BOX: assert property ((fast_req & ~$past(box_any)) == 4'h0)
		else $error("fast request without a nonzero own mailbox");
	AST_FAST_HOLD: assert property ((~fast_req & $past(fast_req) & $past(box_any)) != 4'h0
		|-> $past(acc && pwrite, 2))
		else $error("fast request dropped while mailbox still nonzero");
	AST_MISALIGN: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	AST_CAUSE_WR: assert property (acc && pwrite && paddr[7:4] == 4'h1 |-> pslverr)
		else $error("write to cause register not refused");
	AST_UNMAPPED: assert property (acc && paddr >= 8'h28 |-> pslverr)
		else $error("unmapped access not refused");
	COV_FAST: cover property (fast_req != 4'h0);
	COV_NORM: cover property (normal_req != 4'h0);
	COV_ERR: cover property (acc && pslverr);
endmodule
bind mailbox_irq_router route_checker route_checker_inst (.sys_clk(sys_clk), .rst(rst),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr),
	.box_words(box_words), .fast_req(fast_req), .normal_req(normal_req));

// file: core_model.sv
// Four cores taking the fast and normal requests
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       clr,
	// Requests
	input wire logic [3:0] fast_req,
	input wire logic [3:0] normal_req,
	// Requests seen since clear
	output logic     [3:0] fast_seen_ff,
	output logic     [3:0] norm_seen_ff
);
	always_ff @(posedge sys_clk) begin
		if (rst || clr) begin
			fast_seen_ff <= 4'h0;
			norm_seen_ff <= 4'h0;
		end else begin
			fast_seen_ff <= fast_seen_ff | fast_req;
			norm_seen_ff <= norm_seen_ff | normal_req;
		end
	end
endmodule

// file: testbench.sv
// Self-checking bench of the mailbox interrupt router
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
	logic         sys_clk, rst, psel, penable, pwrite, pready, pslverr, bus_quiet, event_irq, clr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [3:0]   pstrb, timer_i, perf_i, gpu_i, l2_i, fast_req, normal_req, fast_seen, norm_seen;
	logic [511:0] box_words;
	logic [15:0]  tick_normal, lfsr;
	logic [7:0]   ctrl [4];
	logic         err;
	int           n_mismatch, compares;
	mailbox_irq_router mailbox_irq_router_inst (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .box_words(box_words),
		.tick_normal(tick_normal), .local_timer_int(timer_i), .perf_monitor_int(perf_i),
		.gpu_int(gpu_i), .l2_bus_error(l2_i), .bus_quiet(bus_quiet), .fast_req(fast_req),
		.normal_req(normal_req), .event_irq(event_irq));
	core_model core_model_inst (.sys_clk(sys_clk), .rst(rst), .clr(clr), .fast_req(fast_req),
		.normal_req(normal_req), .fast_seen_ff(fast_seen), .norm_seen_ff(norm_seen));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	function automatic logic [31:0] exp_cause(int c);
		logic [31:0] r;
		r = 32'h0;
		for (int k = 0; k < 4; k++) r[4+k] = |box_words[32*(4*c+k) +: 32] && ctrl[c][k] && !ctrl[c][4+k];
		r[3:0] = tick_normal[4*c +: 4];
		r[8] = gpu_i[c];
		r[9] = perf_i[c];
		r[10] = (c == 0) && bus_quiet;
		r[11] = timer_i[c];
		r[30] = l2_i[c];
		return r;
	endfunction
	function automatic logic [3:0] exp_fast();
		logic [3:0] r;
		r = 4'h0;
		for (int c = 0; c < 4; c++) for (int k = 0; k < 4; k++)
			r[c] = r[c] | (|box_words[32*(4*c+k) +: 32] && ctrl[c][4+k]);
		return r;
	endfunction
	task stop_test();
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin n_mismatch++; stop_test(); end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task set_ctrl(int c, logic [31:0] d);
		xfer(1'b1, 8'(4*c), d);
		if (pstrb[0]) ctrl[c] = d[7:0];
		`CHK(err, 1'b0)
	endtask
	task check_pins(string name);
		repeat (2) @(posedge sys_clk);
		`CHK(fast_req, exp_fast())
		for (int c = 0; c < 4; c++) begin
			`CHK(normal_req[c], |exp_cause(c))
			xfer(1'b0, 8'h10 + 8'(4*c), 32'h0);
			`CHK(rd, exp_cause(c))
			xfer(1'b0, 8'(4*c), 32'h0);
			`CHK(rd, {24'h0, ctrl[c]})
		end
		$display("test %s done", name);
	endtask
	initial begin
		logic [15:0] v;
		{rst, psel, penable, pwrite, paddr, pwdata, pstrb, clr} = {4'h8, 8'h0, 32'h0, 4'hf, 1'b0};
		{box_words, tick_normal, timer_i, perf_i, gpu_i, l2_i, bus_quiet} = '0;
		lfsr = 16'hb2ee;
		n_mismatch = 0;
		compares = 0;
		for (int c = 0; c < 4; c++) ctrl[c] = 8'h00;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		check_pins("reset");
		xfer(1'b0, 8'h30, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		xfer(1'b1, 8'h05, 32'hff);
		`CHK(err, 1'b1)
		xfer(1'b1, 8'h10, 32'hffff_ffff);
		`CHK(err, 1'b1)
		pstrb <= 4'h0;
		set_ctrl(1, 32'hff);
		xfer(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'h0)
		pstrb <= 4'hf;
		box_words <= {512{1'b1}};
		for (int c = 0; c < 4; c++) set_ctrl(c, 32'hffff_ff0f | (32'h10 << c));
		check_pins("override");
		repeat (40) begin
			for (int c = 0; c < 4; c++) set_ctrl(c, {rnd(), rnd()});
			for (int m = 0; m < 16; m++) begin
				v = rnd();
				box_words[32*m +: 32] <= v[0] ? (32'h1 << v[5:1]) : 32'h0;
			end
			v = rnd();
			{l2_i, gpu_i, perf_i, timer_i} <= v;
			v = rnd();
			bus_quiet <= v[15];
			tick_normal <= rnd();
			check_pins("random");
		end
		{box_words, tick_normal, timer_i, perf_i, gpu_i, l2_i, bus_quiet} <= '0;
		for (int c = 0; c < 4; c++) set_ctrl(c, 32'h0);
		xfer(1'b1, 8'h24, 32'h0);
		`CHK(err, 1'b0)
		repeat (2) xfer(1'b0, 8'h20, 32'h0);
		clr <= 1'b1;
		set_ctrl(0, 32'h10);
		clr <= 1'b0;
		box_words[0] <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK({event_irq, fast_seen}, 5'h01)
		xfer(1'b1, 8'h24, 32'h01);
		@(posedge sys_clk);
		`CHK(event_irq, 1'b1)
		xfer(1'b0, 8'h20, 32'h0);
		`CHK(rd, 32'h1)
		@(posedge sys_clk);
		`CHK({event_irq, norm_seen}, 5'h00)
		$display("test events done");
		stop_test();
	end
endmodule
